// [rtl/edge_flag.sv]
`timescale 1ns/100ps
// One external request flag: edge detect with selectable polarity,
// set on detection, cleared on vectoring or a software zero write.
module edge_flag (
    input wire logic clk,
    input wire logic rst,
    input wire logic sample_en,
    input wire logic line_in,
    input wire logic rising_sel,
    input wire logic vec_clr,
    input wire logic sw_clr,
    output logic flag
);
    logic line_q;
    logic armed_q;
    logic flag_d;
    wire rise = line_in & ~line_q;
    wire fall = ~line_in & line_q;
    // The first sample only loads the line: an idle-high line would
    // otherwise look like an edge against the reset value.
    wire hit = sample_en & armed_q & (rising_sel ? rise : fall);

    // Set wins over any clear in the same cycle
    assign flag_d = hit | (flag & ~vec_clr & ~sw_clr);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_q <= 1'b0;
            armed_q <= 1'b0;
            flag <= 1'b0;
        end else begin
            if (sample_en) begin
                line_q <= line_in;
                armed_q <= 1'b1;
            end
            flag <= flag_d;
        end
    end
endmodule

// [rtl/irq_ctrl_pkg.sv]
package irq_ctrl_pkg;
    // ------------------------------------------------------------
    // Register addresses in the special function register space
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TTC_REG = 8'h88;
    localparam logic [7:0] ADDR_AUX_EN = 8'h9A;
    localparam logic [7:0] ADDR_MAIN_EN = 8'hA8;
    localparam logic [7:0] ADDR_PRIO_LO = 8'hA9;
    localparam logic [7:0] ADDR_EXT_EN = 8'hB8;
    localparam logic [7:0] ADDR_PRIO_HI = 8'hB9;
    localparam logic [7:0] ADDR_EXT_FLAGS = 8'hC0;
    localparam logic [7:0] ADDR_T2_POL = 8'hC8;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int GLOBAL_EN_BIT = 7;
    localparam int TB_FLAG_BIT = 7;
    localparam int TA_FLAG_BIT = 5;
    localparam int PB_FLAG_BIT = 3;
    localparam int PB_TYPE_BIT = 2;
    localparam int PA_FLAG_BIT = 1;
    localparam int PA_TYPE_BIT = 0;
    localparam int ENGINE_POL_BIT = 6;
    localparam int COLL_POL_BIT = 5;

    // Masks of the bits that each register really holds
    localparam logic [7:0] MAIN_EN_MASK = 8'hDF;
    localparam logic [7:0] EXT_EN_MASK = 8'h3E;
    localparam logic [7:0] AUX_EN_MASK = 8'h01;
    localparam logic [7:0] PRIO_MASK = 8'h3F;
    localparam logic [7:0] T2_POL_MASK = 8'h60;
    localparam logic [7:0] TTC_CTRL_MASK = 8'h55;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // ------------------------------------------------------------
    // Sources, indexed in polling order
    // ------------------------------------------------------------
    localparam int NUM_SRC = 11;
    localparam int NUM_GROUPS = 6;
    localparam int SRC_PIN_A = 0;
    localparam int SRC_SER_B = 1;
    localparam int SRC_TMR_A = 2;
    localparam int SRC_COLL = 3;
    localparam int SRC_PIN_B = 4;
    localparam int SRC_ENGINE = 5;
    localparam int SRC_TMR_B = 6;
    localparam int SRC_PLL = 7;
    localparam int SRC_SER_A = 8;
    localparam int SRC_EEPROM = 9;
    localparam int SRC_MISC = 10;

    // Vector table, one slot per source
    localparam logic [15:0] VEC_PIN_A = 16'h0003;
    localparam logic [15:0] VEC_SER_B = 16'h0083;
    localparam logic [15:0] VEC_TMR_A = 16'h000B;
    localparam logic [15:0] VEC_COLL = 16'h004B;
    localparam logic [15:0] VEC_PIN_B = 16'h0013;
    localparam logic [15:0] VEC_ENGINE = 16'h0053;
    localparam logic [15:0] VEC_TMR_B = 16'h001B;
    localparam logic [15:0] VEC_PLL = 16'h005B;
    localparam logic [15:0] VEC_SER_A = 16'h0023;
    localparam logic [15:0] VEC_EEPROM = 16'h0063;
    localparam logic [15:0] VEC_MISC = 16'h006B;

    typedef enum logic [1:0] {
        LVL_0,
        LVL_1,
        LVL_2,
        LVL_3
    } level_t;
endpackage

// [rtl/mpu_interrupt_controller.sv]
`timescale 1ns/100ps
// Functional notes
// - Eleven sources, four priority levels, visible flags
// - Each source masked by its enable bit
// - Accepted request calls its fixed vector
// - Only strictly higher level preempts active service
// - Return-from-interrupt ends the active level
// - Flags set regardless of enable bits
// - Flags sampled once per machine cycle
// - Registered request acknowledged next instruction cycle
// - Defer after return or enable/priority write
// - Global enable bit 7 blocks everything
// - Main enable register source bit layout
// - External enable bits 5..1 for sources 6..2
// - Sources 2, 4 and 6 merge their peripheral events
// - Auxiliary enable bit 0 for serial B
// - Timer control register holds four flags
// - Pin sources: 0 level, 1 falling edge
// - Polarity bits for sources 3 and 2
// - Request register bits 5..1 show pending
// - Timer flags cleared on call, ack pulses
// - External flags cleared on vectoring, except source 6
// - Two priority bits give four levels
// - Software clears flags by writing zero only
module mpu_interrupt_controller (
    input wire logic CLK,
    input wire logic RST,
    // Register port from the core
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    // Core timing and handshake
    input wire logic MACHINE_CYCLE,
    input wire logic INSTR_END,
    input wire logic RETI_EXEC,
    output logic IRQ_CALL,
    output logic [15:0] IRQ_VECTOR,
    output logic TIMER_A_SERVICE_ACK,
    output logic TIMER_B_SERVICE_ACK,
    // Request sources
    input wire logic TIMER_A_OVERFLOW,
    input wire logic TIMER_B_OVERFLOW,
    input wire logic SERIAL_A_REQ,
    input wire logic SERIAL_B_REQ,
    input wire logic PIN_IRQ_A_N,
    input wire logic PIN_IRQ_B_N,
    input wire logic FLASH_WRITE_COLLISION_A,
    input wire logic FLASH_WRITE_COLLISION_B,
    input wire logic SPI_REQ,
    input wire logic ENGINE_BUSY,
    input wire logic PLL_LOCK_RISE,
    input wire logic PLL_LOCK_FALL,
    input wire logic EEPROM_BUSY_N,
    input wire logic TRANSFER_IN_PROGRESS_N,
    input wire logic ONE_SECOND_TICK_N,
    input wire logic WATCHDOG_NEAR_OVERFLOW_N
);
    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic [7:0] main_en_q, ext_en_q, aux_en_q, prio_lo_q, prio_hi_q, t2_pol_q, ttc_ctrl_q;
    wire wr_ttc = SFR_WR && SFR_ADDR == irq_ctrl_pkg::ADDR_TTC_REG;
    wire wr_main = SFR_WR && SFR_ADDR == irq_ctrl_pkg::ADDR_MAIN_EN;
    wire wr_ext = SFR_WR && SFR_ADDR == irq_ctrl_pkg::ADDR_EXT_EN;
    wire wr_aux = SFR_WR && SFR_ADDR == irq_ctrl_pkg::ADDR_AUX_EN;
    wire wr_plo = SFR_WR && SFR_ADDR == irq_ctrl_pkg::ADDR_PRIO_LO;
    wire wr_phi = SFR_WR && SFR_ADDR == irq_ctrl_pkg::ADDR_PRIO_HI;
    wire wr_flags = SFR_WR && SFR_ADDR == irq_ctrl_pkg::ADDR_EXT_FLAGS;
    wire wr_t2 = SFR_WR && SFR_ADDR == irq_ctrl_pkg::ADDR_T2_POL;
    wire defer_wr = wr_main | wr_ext | wr_aux | wr_plo | wr_phi;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            main_en_q <= irq_ctrl_pkg::RESET_BYTE;
            ext_en_q <= irq_ctrl_pkg::RESET_BYTE;
            aux_en_q <= irq_ctrl_pkg::RESET_BYTE;
            prio_lo_q <= irq_ctrl_pkg::RESET_BYTE;
            prio_hi_q <= irq_ctrl_pkg::RESET_BYTE;
            t2_pol_q <= irq_ctrl_pkg::RESET_BYTE;
            ttc_ctrl_q <= irq_ctrl_pkg::RESET_BYTE;
        end else begin
            if (wr_main) main_en_q <= SFR_WDATA & irq_ctrl_pkg::MAIN_EN_MASK;
            if (wr_ext) ext_en_q <= SFR_WDATA & irq_ctrl_pkg::EXT_EN_MASK;
            if (wr_aux) aux_en_q <= SFR_WDATA & irq_ctrl_pkg::AUX_EN_MASK;
            if (wr_plo) prio_lo_q <= SFR_WDATA & irq_ctrl_pkg::PRIO_MASK;
            if (wr_phi) prio_hi_q <= SFR_WDATA & irq_ctrl_pkg::PRIO_MASK;
            if (wr_t2) t2_pol_q <= SFR_WDATA & irq_ctrl_pkg::T2_POL_MASK;
            if (wr_ttc) ttc_ctrl_q <= SFR_WDATA & irq_ctrl_pkg::TTC_CTRL_MASK;
        end
    end

    // ------------------------------------------------------------
    // Request flags
    // ------------------------------------------------------------
    logic ta_flag_q, tb_flag_q, pa_edge_q, pb_edge_q, pa_line_q, pb_line_q;
    logic [10:0] flag;
    logic [10:0] vec_clr;
    wire pa_type = ttc_ctrl_q[irq_ctrl_pkg::PA_TYPE_BIT];
    wire pb_type = ttc_ctrl_q[irq_ctrl_pkg::PB_TYPE_BIT];
    wire s = MACHINE_CYCLE;
    // Edge latch runs in edge mode only, so a mode switch finds no stale edge
    wire pa_fall = s & pa_type & pa_line_q & ~PIN_IRQ_A_N;
    wire pb_fall = s & pb_type & pb_line_q & ~PIN_IRQ_B_N;
    // Zero written clears, one written leaves the flag alone
    wire clr_ta = wr_ttc & ~SFR_WDATA[irq_ctrl_pkg::TA_FLAG_BIT];
    wire clr_tb = wr_ttc & ~SFR_WDATA[irq_ctrl_pkg::TB_FLAG_BIT];
    wire clr_pa = wr_ttc & ~SFR_WDATA[irq_ctrl_pkg::PA_FLAG_BIT];
    wire clr_pb = wr_ttc & ~SFR_WDATA[irq_ctrl_pkg::PB_FLAG_BIT];

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ta_flag_q <= 1'b0;
            tb_flag_q <= 1'b0;
            pa_edge_q <= 1'b0;
            pb_edge_q <= 1'b0;
            pa_line_q <= 1'b1;
            pb_line_q <= 1'b1;
        end else begin
            // Set wins over hardware and software clears
            ta_flag_q <= TIMER_A_OVERFLOW | (ta_flag_q & ~vec_clr[irq_ctrl_pkg::SRC_TMR_A] & ~clr_ta);
            tb_flag_q <= TIMER_B_OVERFLOW | (tb_flag_q & ~vec_clr[irq_ctrl_pkg::SRC_TMR_B] & ~clr_tb);
            pa_edge_q <= pa_fall | (pa_edge_q & ~vec_clr[irq_ctrl_pkg::SRC_PIN_A] & ~clr_pa);
            pb_edge_q <= pb_fall | (pb_edge_q & ~vec_clr[irq_ctrl_pkg::SRC_PIN_B] & ~clr_pb);
            if (s) begin
                pa_line_q <= PIN_IRQ_A_N;
                pb_line_q <= PIN_IRQ_B_N;
            end
        end
    end

    // Level mode tracks the pin, so it cannot be cleared while low
    wire pa_flag = pa_type ? pa_edge_q : ~PIN_IRQ_A_N;
    wire pb_flag = pb_type ? pb_edge_q : ~PIN_IRQ_B_N;

    // Merged external lines, active low to match falling edges, except the active-high PLL line
    wire coll_line = ~(FLASH_WRITE_COLLISION_A | FLASH_WRITE_COLLISION_B | SPI_REQ);
    wire engine_line = ~ENGINE_BUSY;
    wire pll_line = PLL_LOCK_RISE | PLL_LOCK_FALL;
    wire misc_line = TRANSFER_IN_PROGRESS_N & ONE_SECOND_TICK_N & WATCHDOG_NEAR_OVERFLOW_N;
    wire [4:0] ext_line = {misc_line, EEPROM_BUSY_N, pll_line, engine_line, coll_line};
    // Sources 2 and 3 programmable, 4 rising, 5 and 6 falling
    wire [4:0] ext_rise = {1'b0, 1'b0, 1'b1, ~t2_pol_q[irq_ctrl_pkg::ENGINE_POL_BIT],
        ~t2_pol_q[irq_ctrl_pkg::COLL_POL_BIT]};
    wire [4:0] ext_vclr = {vec_clr[irq_ctrl_pkg::SRC_MISC], vec_clr[irq_ctrl_pkg::SRC_EEPROM],
        vec_clr[irq_ctrl_pkg::SRC_PLL], vec_clr[irq_ctrl_pkg::SRC_ENGINE],
        vec_clr[irq_ctrl_pkg::SRC_COLL]};
    logic [4:0] ext_flag;

    // Lines are inverted before edge detection, so polarity 1 means
    // falling detection on the inverted line for sources 2 and 3.
    for (genvar g = 0; g < 5; g++) begin : g_ext
        edge_flag u_flag (
            .clk(CLK),
            .rst(RST),
            .sample_en(s),
            .line_in(ext_line[g]),
            .rising_sel(ext_rise[g]),
            .vec_clr(ext_vclr[g]),
            .sw_clr(wr_flags & ~SFR_WDATA[g + 1]),
            .flag(ext_flag[g])
        );
    end

    // Flags in polling order
    assign flag = {ext_flag[4], ext_flag[3], SERIAL_A_REQ, ext_flag[2], tb_flag_q,
        ext_flag[1], pb_flag, ext_flag[0], ta_flag_q, SERIAL_B_REQ, pa_flag};

    // ------------------------------------------------------------
    // Enables and levels
    // ------------------------------------------------------------
    wire [10:0] enable = {ext_en_q[5], ext_en_q[4], main_en_q[4], ext_en_q[3], main_en_q[3],
        ext_en_q[2], main_en_q[2], ext_en_q[1], main_en_q[1], aux_en_q[0], main_en_q[0]};
    wire global_irq_enable = main_en_q[irq_ctrl_pkg::GLOBAL_EN_BIT];
    wire [10:0] req = flag & enable & {irq_ctrl_pkg::NUM_SRC{global_irq_enable}};

    // Group g holds sources 2g and 2g+1
    logic [21:0] lvl;
    always_comb begin
        for (int i = 0; i < irq_ctrl_pkg::NUM_SRC; i++) begin
            lvl[2*i +: 2] = {prio_hi_q[i/2], prio_lo_q[i/2]};
        end
    end

    logic found;
    logic [3:0] pick;
    logic [1:0] pick_lvl;
    priority_pick u_pick (
        .req(req),
        .lvl(lvl),
        .found(found),
        .idx(pick),
        .level(pick_lvl)
    );

    // ------------------------------------------------------------
    // Acceptance and service tracking
    // ------------------------------------------------------------
    logic [3:0] active_q;
    logic reg_valid_q, defer_q;
    logic [3:0] reg_idx_q;
    logic [1:0] reg_lvl_q;
    logic [3:0] top_active;
    logic any_active;
    always_comb begin
        any_active = 1'b0;
        top_active = 4'h0;
        for (int l = 0; l < 4; l++) begin
            if (active_q[l]) begin
                any_active = 1'b1;
                top_active = 4'(l);
            end
        end
    end
    // Strictly higher than any running service
    wire lvl_ok = !any_active || 4'(pick_lvl) > top_active;
    wire reg_ok = !any_active || 4'(reg_lvl_q) > top_active;
    wire take = reg_valid_q && INSTR_END && !defer_q && !RETI_EXEC && !defer_wr && reg_ok;

    logic [15:0] vec_sel;
    always_comb begin
        case (reg_idx_q)
            4'h0: vec_sel = irq_ctrl_pkg::VEC_PIN_A;
            4'h1: vec_sel = irq_ctrl_pkg::VEC_SER_B;
            4'h2: vec_sel = irq_ctrl_pkg::VEC_TMR_A;
            4'h3: vec_sel = irq_ctrl_pkg::VEC_COLL;
            4'h4: vec_sel = irq_ctrl_pkg::VEC_PIN_B;
            4'h5: vec_sel = irq_ctrl_pkg::VEC_ENGINE;
            4'h6: vec_sel = irq_ctrl_pkg::VEC_TMR_B;
            4'h7: vec_sel = irq_ctrl_pkg::VEC_PLL;
            4'h8: vec_sel = irq_ctrl_pkg::VEC_SER_A;
            4'h9: vec_sel = irq_ctrl_pkg::VEC_EEPROM;
            default: vec_sel = irq_ctrl_pkg::VEC_MISC;
        endcase
    end

    // Clear pulse for the vectored source; the misc source keeps its flag
    // since its sub-flags are cleared by the handler.
    always_comb begin
        vec_clr = '0;
        if (take && reg_idx_q != 4'(irq_ctrl_pkg::SRC_MISC)) begin
            vec_clr[reg_idx_q] = 1'b1;
        end
    end

    // Highest active bit dropped on return
    logic [3:0] end_mask;
    always_comb begin
        end_mask = '0;
        end_mask[top_active[1:0]] = RETI_EXEC & any_active;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            reg_valid_q <= 1'b0;
            reg_idx_q <= 4'h0;
            reg_lvl_q <= 2'h0;
            defer_q <= 1'b0;
            active_q <= 4'h0;
            IRQ_CALL <= 1'b0;
            IRQ_VECTOR <= 16'h0000;
            TIMER_A_SERVICE_ACK <= 1'b0;
            TIMER_B_SERVICE_ACK <= 1'b0;
        end else begin
            // Poll on each machine cycle; a taken request is consumed
            if (take) begin
                reg_valid_q <= 1'b0;
            end else if (s) begin
                reg_valid_q <= found && lvl_ok;
                reg_idx_q <= pick;
                reg_lvl_q <= pick_lvl;
            end
            // Holds the deferral across the instruction that caused it
            if (INSTR_END) begin
                defer_q <= 1'b0;
            end else if (RETI_EXEC || defer_wr) begin
                defer_q <= 1'b1;
            end
            active_q <= (active_q & ~end_mask) | (take ? 4'(1) << reg_lvl_q : 4'h0);
            IRQ_CALL <= take;
            if (take) IRQ_VECTOR <= vec_sel;
            TIMER_A_SERVICE_ACK <= take && reg_idx_q == 4'(irq_ctrl_pkg::SRC_TMR_A);
            TIMER_B_SERVICE_ACK <= take && reg_idx_q == 4'(irq_ctrl_pkg::SRC_TMR_B);
        end
    end

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    wire [7:0] ttc_rd = ttc_ctrl_q | {tb_flag_q, 1'b0, ta_flag_q, 1'b0, pb_flag, 1'b0,
        pa_flag, 1'b0};
    wire [7:0] flags_rd = {2'b00, ext_flag, 1'b0};
    always_comb begin
        case (SFR_ADDR)
            irq_ctrl_pkg::ADDR_TTC_REG: SFR_RDATA = ttc_rd;
            irq_ctrl_pkg::ADDR_AUX_EN: SFR_RDATA = aux_en_q;
            irq_ctrl_pkg::ADDR_MAIN_EN: SFR_RDATA = main_en_q;
            irq_ctrl_pkg::ADDR_PRIO_LO: SFR_RDATA = prio_lo_q;
            irq_ctrl_pkg::ADDR_EXT_EN: SFR_RDATA = ext_en_q;
            irq_ctrl_pkg::ADDR_PRIO_HI: SFR_RDATA = prio_hi_q;
            irq_ctrl_pkg::ADDR_EXT_FLAGS: SFR_RDATA = flags_rd;
            irq_ctrl_pkg::ADDR_T2_POL: SFR_RDATA = t2_pol_q;
            default: SFR_RDATA = 8'h00;
        endcase
    end
endmodule

// [rtl/priority_pick.sv]
`timescale 1ns/100ps
// Picks the highest-level request; ties go to the lowest index,
// which is the fixed polling order.
module priority_pick (
    input wire logic [10:0] req,
    input wire logic [21:0] lvl,
    output logic found,
    output logic [3:0] idx,
    output logic [1:0] level
);
    always_comb begin
        found = 1'b0;
        idx = 4'h0;
        level = 2'h0;
        for (int i = 0; i < irq_ctrl_pkg::NUM_SRC; i++) begin
            if (req[i] && (!found || lvl[2*i +: 2] > level)) begin
                found = 1'b1;
                idx = 4'(i);
                level = lvl[2*i +: 2];
            end
        end
    end
endmodule

// [tb/core_model.sv]
`timescale 1ns/100ps
// Two clocks per machine cycle, two machine cycles per instruction
module core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic reti_req,
    output logic machine_cycle,
    output logic instr_end,
    output logic reti_exec
);
    logic [1:0] cnt_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
    assign machine_cycle = cnt_q[0];
    assign instr_end = (cnt_q == 2'h3);
    // A return only completes on an instruction end
    assign reti_exec = instr_end && reti_req;
endmodule

// [tb/mpu_interrupt_controller_sva.sv]
`timescale 1ns/100ps
module irq_ctrl_check (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic [7:0] SFR_RDATA,
    input wire logic INSTR_END,
    input wire logic RETI_EXEC,
    input wire logic IRQ_CALL,
    input wire logic [15:0] IRQ_VECTOR,
    input wire logic TIMER_A_SERVICE_ACK,
    input wire logic TIMER_B_SERVICE_ACK,
    input wire logic TIMER_A_OVERFLOW
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // ----
    // Shadow state
    // ----
    logic cfg_wr;
    logic mapped;
    logic since_q;
    logic glob_q;
    logic [3:0] off_q;
    assign cfg_wr = SFR_WR && (SFR_ADDR inside {8'h9A, 8'hA8, 8'hA9, 8'hB8, 8'hB9});
    assign mapped = SFR_ADDR inside {8'h88, 8'h9A, 8'hA8, 8'hA9, 8'hB8, 8'hB9, 8'hC0, 8'hC8};
    // A write on the ending cycle itself is left out: only that end is surely deferred
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            since_q <= 1'b0;
            glob_q <= 1'b0;
            off_q <= 4'h0;
        end else begin
            since_q <= !INSTR_END && (cfg_wr || since_q);
            if (SFR_WR && SFR_ADDR == 8'hA8) begin
                glob_q <= SFR_WDATA[7];
            end
            off_q <= glob_q ? 4'h0 : ((off_q == 4'hF) ? off_q : off_q + 4'h1);
        end
    end
    sequence deferred_s;
        INSTR_END && (RETI_EXEC || cfg_wr || since_q);
    endsequence
    call_after_end_a: assert property (IRQ_CALL |-> $past(INSTR_END))
        else $error("call without instruction end");
    call_deferred_a: assert property (deferred_s |=> !IRQ_CALL)
        else $error("call not deferred");
    call_pulse_a: assert property (IRQ_CALL |=> !IRQ_CALL)
        else $error("call longer than one cycle");
    timer_ack_a: assert property ({TIMER_B_SERVICE_ACK, TIMER_A_SERVICE_ACK} ==
        {IRQ_CALL && IRQ_VECTOR == 16'h001B, IRQ_CALL && IRQ_VECTOR == 16'h000B})
        else $error("timer ack mismatch");
    vector_hold_a: assert property (!IRQ_CALL |-> $stable(IRQ_VECTOR))
        else $error("vector moved without call");
    vector_table_a: assert property (IRQ_CALL |-> IRQ_VECTOR inside {16'h0003,
        16'h0083, 16'h000B, 16'h004B, 16'h0013, 16'h0053, 16'h001B, 16'h005B, 16'h0023,
        16'h0063, 16'h006B})
        else $error("vector outside table");
    global_gate_a: assert property (IRQ_CALL |-> off_q < 4'h2)
        else $error("call with global enable off");
    unmapped_zero_a: assert property (!mapped |-> SFR_RDATA == 8'h00)
        else $error("unmapped read not zero");
    reserved_bits_a: assert property (SFR_ADDR inside {8'hB8, 8'hC0} |->
        (SFR_RDATA & 8'hC1) == 8'h00)
        else $error("unused bit reads one");
    timer_set_a: assert property (TIMER_A_OVERFLOW |=>
        (SFR_ADDR != 8'h88 || SFR_RDATA[5]))
        else $error("overflow flag not set");
    timer_clear_a: assert property (TIMER_A_SERVICE_ACK && !$past(TIMER_A_OVERFLOW) &&
        SFR_ADDR == 8'h88 |-> !SFR_RDATA[5])
        else $error("overflow flag not cleared");
endmodule
bind mpu_interrupt_controller irq_ctrl_check i_chk (.CLK(CLK), .RST(RST),
    .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
    .INSTR_END(INSTR_END), .RETI_EXEC(RETI_EXEC), .IRQ_CALL(IRQ_CALL),
    .IRQ_VECTOR(IRQ_VECTOR), .TIMER_A_SERVICE_ACK(TIMER_A_SERVICE_ACK),
    .TIMER_B_SERVICE_ACK(TIMER_B_SERVICE_ACK), .TIMER_A_OVERFLOW(TIMER_A_OVERFLOW));

// [tb/mpu_interrupt_controller_tb.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module mpu_interrupt_controller_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic we = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [15:0] act = 16'h0000;
    logic reti_req = 1'b0;
    logic [7:0] rdata;
    logic mc, ie, rx, call, ack_a, ack_b;
    logic [15:0] vec;
    int n_tests = 0;
    int bad_count = 0;
    logic [15:0] vec_tab [11] = '{16'h0003, 16'h0083, 16'h000B, 16'h004B, 16'h0013,
        16'h0053, 16'h001B, 16'h005B, 16'h0023, 16'h0063, 16'h006B};
    logic [23:0] en_tab [11] = '{24'h01_0000, 24'h00_0001, 24'h02_0000, 24'h00_0200,
        24'h04_0000, 24'h00_0400, 24'h08_0000, 24'h00_0800, 24'h10_0000, 24'h00_1000,
        24'h00_2000};
    logic [15:0] fl_tab [11] = '{16'h8802, 16'h8800, 16'h8820, 16'hC002, 16'h8808,
        16'hC004, 16'h8880, 16'hC008, 16'h8800, 16'hC010, 16'hC020};
    int ev_src [16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 3, 3, 7, 10, 10};
    int ev_len [16] = '{4, 0, 1, 4, 4, 4, 1, 4, 0, 4, 4, 4, 4, 4, 4, 4};
    logic [7:0] reg_tab [9] = '{8'h88, 8'h9A, 8'hA8, 8'hA9, 8'hB8, 8'hB9, 8'hC0, 8'hC8, 8'h90};
    logic [7:0] msk_tab [9] = '{8'h55, 8'h01, 8'hDF, 8'h3F, 8'h3E, 8'h3F, 8'h00, 8'h60, 8'h00};
    mpu_interrupt_controller i_dut (.CLK(clk), .RST(rst), .SFR_ADDR(addr), .SFR_WR(we),
        .SFR_WDATA(wdata), .SFR_RDATA(rdata), .MACHINE_CYCLE(mc), .INSTR_END(ie),
        .RETI_EXEC(rx), .IRQ_CALL(call), .IRQ_VECTOR(vec), .TIMER_A_SERVICE_ACK(ack_a),
        .TIMER_B_SERVICE_ACK(ack_b), .TIMER_A_OVERFLOW(act[2]), .TIMER_B_OVERFLOW(act[6]),
        .SERIAL_A_REQ(act[8]), .SERIAL_B_REQ(act[1]), .PIN_IRQ_A_N(!act[0]),
        .PIN_IRQ_B_N(!act[4]), .FLASH_WRITE_COLLISION_A(act[3]),
        .FLASH_WRITE_COLLISION_B(act[11]), .SPI_REQ(act[12]), .ENGINE_BUSY(act[5]),
        .PLL_LOCK_RISE(act[7]), .PLL_LOCK_FALL(act[13]), .EEPROM_BUSY_N(!act[9]),
        .TRANSFER_IN_PROGRESS_N(!act[10]), .ONE_SECOND_TICK_N(!act[14]),
        .WATCHDOG_NEAR_OVERFLOW_N(!act[15]));
    core_model i_core (.clk(clk), .rst(rst), .reti_req(reti_req), .machine_cycle(mc),
        .instr_end(ie), .reti_exec(rx));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // ----
    // Access tasks
    // ----
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
    endtask
    task automatic cr(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        #1;
        `CHK(rdata, e)
    endtask
    task automatic no_call(input int k);
        repeat (k) begin
            @(negedge clk);
            `CHK(call, 1'b0)
        end
    endtask
    task automatic wait_call(input logic [15:0] v, input logic [1:0] ak);
        int n;
        n = 0;
        addr = 8'h88;
        while (call !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        `CHK(vec, v)
        `CHK({ack_b, ack_a}, ak)
        if (call !== 1'b1) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    task automatic end_service();
        int n;
        n = 0;
        @(negedge clk);
        reti_req = 1'b1;
        while (rx !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        if (rx !== 1'b1) bad_count++;
        @(negedge clk);
        reti_req = 1'b0;
    endtask
    // Serial requests are levels held until the call; the rest are pulses
    task automatic pulse(input int e);
        @(negedge clk);
        addr = 8'h88;
        act[e] = 1'b1;
        repeat (ev_len[e]) @(negedge clk);
        if (ev_len[e] != 0) act[e] = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    task automatic run_src(input int e);
        int s;
        logic [7:0] fa, fm, base;
        s = ev_src[e];
        fa = fl_tab[s][15:8];
        fm = fl_tab[s][7:0];
        base = (fa == 8'h88) ? 8'h05 : 8'h00;
        pulse(e);
        cr(fa, fm | base);
        wr(8'hA8, 8'h80 | en_tab[s][23:16]);
        wr(8'hB8, en_tab[s][15:8]);
        wr(8'h9A, en_tab[s][7:0]);
        wait_call(vec_tab[s], {s == 6, s == 2});
        act[e] = 1'b0;
        wr(8'hA8, 8'h00);
        cr(fa, ((s == 10) ? fm : 8'h00) | base);
        wr(8'hC0, 8'h00);
        end_service();
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 9; i++) begin
            cr(reg_tab[i], 8'h00);
            wr(reg_tab[i], 8'hFF);
            cr(reg_tab[i], msk_tab[i]);
            wr(reg_tab[i], 8'h00);
        end
        $display("test registers done");
        act[0] = 1'b1;
        repeat (4) @(negedge clk);
        cr(8'h88, 8'h02);
        act[0] = 1'b0;
        repeat (4) @(negedge clk);
        cr(8'h88, 8'h00);
        $display("test level trigger done");
        wr(8'h88, 8'h05);
        wr(8'hA8, 8'h02);
        pulse(2);
        no_call(16);
        wr(8'hA8, 8'h82);
        wait_call(16'h000B, 2'b01);
        wr(8'hA8, 8'h00);
        end_service();
        $display("test global enable done");
        for (int e = 0; e < 16; e++) run_src(e);
        wr(8'hC8, 8'h40);
        act[5] = 1'b1;
        repeat (4) @(negedge clk);
        cr(8'hC0, 8'h04);
        act[5] = 1'b0;
        wr(8'hC0, 8'h00);
        wr(8'hC8, 8'h00);
        $display("test sources done");
        wr(8'hA9, 8'h04);
        wr(8'hB9, 8'h04);
        pulse(2);
        wr(8'hA8, 8'h86);
        wait_call(16'h000B, 2'b01);
        pulse(2);
        no_call(16);
        act[4] = 1'b1;
        wait_call(16'h0013, 2'b00);
        act[4] = 1'b0;
        end_service();
        no_call(16);
        end_service();
        wait_call(16'h000B, 2'b01);
        end_service();
        wr(8'hA8, 8'h00);
        wr(8'hB9, 8'h00);
        wr(8'hA9, 8'h00);
        pulse(2);
        pulse(0);
        wr(8'hA8, 8'h83);
        wait_call(16'h0003, 2'b00);
        end_service();
        wait_call(16'h000B, 2'b01);
        wr(8'hA8, 8'h00);
        end_service();
        $display("test priority done");
        tally_and_finish();
    end
endmodule
